//--- hw/dsg_pkg.sv
package dsg_pkg;
    // register byte offsets within the system-control block
    localparam logic [11:0] RUN_CLOCK_CONFIG_OFF = 12'h060;
    localparam logic [11:0] RUN_GATE_OFF         = 12'h104;
    localparam logic [11:0] SLEEP_GATE_OFF       = 12'h114;
    localparam logic [11:0] DEEP_SLEEP_GATE_OFF  = 12'h124;
    localparam logic [11:0] IRQ_STATUS_OFF       = 12'h200;
    localparam logic [11:0] IRQ_MASK_OFF         = 12'h204;
    localparam logic [11:0] FAULT_ADDR_OFF       = 12'h208;

    // implemented gate bits, everything else reserved
    localparam logic [31:0] GATE_WR_MASK   = 32'h030F_5033;
    localparam logic [31:0] GATE_RESET     = 32'h0000_0000;
    localparam int          AUTO_GATE_BIT  = 27;
    localparam int          NUM_GATES      = 32;

    // interrupt status layout
    localparam int          IRQ_FAULT_BIT  = 0;
    localparam int          IRQ_MODE_BIT   = 1;
    localparam logic [31:0] IRQ_WR_MASK    = 32'h0000_0003;

    // peripheral window: each unit owns one 4 KiB page, indexed by gate bit
    localparam int          PERIPH_PAGE_LSB = 12;
    localparam int          PERIPH_PAGE_W   = 5;

    typedef enum logic [1:0] {
        DSG_MODE_RUN,
        DSG_MODE_SLEEP,
        DSG_MODE_DEEP
    } dsg_mode_t;
endpackage : dsg_pkg

//--- hw/dsg_gate_bank.sv
// Local design decision: the APB interface to the registers.
`timescale 1ns/10ps

// Functional notes
// - each implemented gate bit at one lets its unit run with a clock, at zero stops and disables it.
// - a bus access to a unit whose clock is currently gated off is answered with a bus fault.
// - reset clears every gate bit so the register reads zero and all units start off.
// - the deep-sleep gate register is a 32-bit word at offset 0x124 of the system-control block.
// - run, sleep and deep-sleep gate registers of one layout apply in their own power mode.
// - sleep and deep-sleep gates apply only while the auto gate select bit is set, else run gates hold.
// - bits 19 to 16 gate general-purpose counters d, c, b and a.
// - bit 14 gates two-wire module b and bit 12 gates two-wire module a.
// - bit 5 gates synchronous serial module b and bit 4 gates module a.
// - bit 1 gates asynchronous serial module b and bit 0 gates module a.
// - reserved bits read zero and ignore writes.
module dsg_gate_bank (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // apb slave, system-control registers
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // power mode request from the core
    input  wire logic        sleep_req,
    input  wire logic        deep_sleep_req,
    // peripheral bus watch and fault answer
    input  wire logic        periph_sel,
    input  wire logic [dsg_pkg::PERIPH_PAGE_W-1:0] periph_page,
    output logic             periph_fault,
    // per-unit clock enables, bit positions as in the gate registers
    output logic      [31:0] unit_clk_en,
    output logic      [31:0] unit_enable,
    // interrupt
    output logic             irq
);
    localparam int PERIPH_W = dsg_pkg::PERIPH_PAGE_W;

    logic [31:0]       run_gate_q, run_gate_d;
    logic [31:0]       sleep_gate_q, sleep_gate_d;
    logic [31:0]       deep_gate_q, deep_gate_d;
    logic              auto_gate_q, auto_gate_d;
    logic [31:0]       irq_stat_q, irq_stat_d;
    logic [31:0]       irq_mask_q, irq_mask_d;
    logic [31:0]       fault_addr_q, fault_addr_d;
    logic [31:0]       prdata_q, prdata_d;
    logic              pslverr_q, pslverr_d;
    logic [31:0]       gate_q, gate_d;
    logic              fault_q, fault_d;
    dsg_pkg::dsg_mode_t mode_q, mode_d;

    logic              wr_en;
    logic              rd_en;
    logic              addr_hit;
    logic [31:0]       irq_evt;

    // byte-lane merge, restricted to writable bits
    function automatic logic [31:0] merge_wr(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb, input logic [31:0] wmask);
        logic [31:0] lane;
        lane = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wmask;
        merge_wr = (old_v & ~lane) | (new_v & lane);
    endfunction : merge_wr

    // reads are captured in setup so data stands at the ready edge; writes land on the ready edge only
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;

    always_comb begin
        addr_hit = 1'b1;
        prdata_d = 32'h0000_0000;
        unique case (paddr)
            dsg_pkg::RUN_CLOCK_CONFIG_OFF: prdata_d[dsg_pkg::AUTO_GATE_BIT] = auto_gate_q;
            dsg_pkg::RUN_GATE_OFF:         prdata_d = run_gate_q;
            dsg_pkg::SLEEP_GATE_OFF:       prdata_d = sleep_gate_q;
            dsg_pkg::DEEP_SLEEP_GATE_OFF:  prdata_d = deep_gate_q;
            dsg_pkg::IRQ_STATUS_OFF:       prdata_d = irq_stat_q;
            dsg_pkg::IRQ_MASK_OFF:         prdata_d = irq_mask_q;
            dsg_pkg::FAULT_ADDR_OFF:       prdata_d = fault_addr_q;
            default:                       addr_hit = 1'b0;
        endcase
        if (!rd_en) begin
            prdata_d = prdata_q;
        end
        pslverr_d = pslverr_q;
        if (psel && !penable) begin
            pslverr_d = !addr_hit;
        end
    end

    // register writes; reserved bits are masked out and stay zero
    always_comb begin
        run_gate_d   = run_gate_q;
        sleep_gate_d = sleep_gate_q;
        deep_gate_d  = deep_gate_q;
        auto_gate_d  = auto_gate_q;
        irq_mask_d   = irq_mask_q;
        if (wr_en) begin
            unique case (paddr)
                dsg_pkg::RUN_CLOCK_CONFIG_OFF: begin
                    if (pstrb[dsg_pkg::AUTO_GATE_BIT / 8]) begin
                        auto_gate_d = pwdata[dsg_pkg::AUTO_GATE_BIT];
                    end
                end
                dsg_pkg::RUN_GATE_OFF:
                    run_gate_d = merge_wr(run_gate_q, pwdata, pstrb, dsg_pkg::GATE_WR_MASK);
                dsg_pkg::SLEEP_GATE_OFF:
                    sleep_gate_d = merge_wr(sleep_gate_q, pwdata, pstrb, dsg_pkg::GATE_WR_MASK);
                dsg_pkg::DEEP_SLEEP_GATE_OFF:
                    deep_gate_d = merge_wr(deep_gate_q, pwdata, pstrb,
                                           dsg_pkg::GATE_WR_MASK);
                dsg_pkg::IRQ_MASK_OFF:
                    irq_mask_d = merge_wr(irq_mask_q, pwdata, pstrb, dsg_pkg::IRQ_WR_MASK);
                default: ;
            endcase
        end
    end

    // mode selection and the gate set in force
    always_comb begin
        mode_d = dsg_pkg::DSG_MODE_RUN;
        if (auto_gate_q && deep_sleep_req) begin
            mode_d = dsg_pkg::DSG_MODE_DEEP;
        end else if (auto_gate_q && sleep_req) begin
            mode_d = dsg_pkg::DSG_MODE_SLEEP;
        end
        unique case (mode_d)
            dsg_pkg::DSG_MODE_RUN:   gate_d = run_gate_d;
            dsg_pkg::DSG_MODE_SLEEP: gate_d = sleep_gate_d;
            dsg_pkg::DSG_MODE_DEEP:  gate_d = deep_gate_d;
            default:                 gate_d = run_gate_d;
        endcase
    end

    // access to a gated unit faults instead of transferring
    always_comb begin
        fault_d      = periph_sel && !gate_q[periph_page];
        fault_addr_d = fault_addr_q;
        if (fault_d) begin
            fault_addr_d = {27'h000_0000, periph_page};
        end
        irq_evt = 32'h0000_0000;
        irq_evt[dsg_pkg::IRQ_FAULT_BIT] = fault_d;
        irq_evt[dsg_pkg::IRQ_MODE_BIT]  = (mode_d != mode_q);
        // event set wins over a same-cycle write-one clear
        irq_stat_d = irq_stat_q;
        if (wr_en && paddr == dsg_pkg::IRQ_STATUS_OFF) begin
            irq_stat_d = irq_stat_q & ~(pwdata & dsg_pkg::IRQ_WR_MASK);
        end
        irq_stat_d = irq_stat_d | irq_evt;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            run_gate_q   <= dsg_pkg::GATE_RESET;
            sleep_gate_q <= dsg_pkg::GATE_RESET;
            deep_gate_q  <= dsg_pkg::GATE_RESET;
            gate_q       <= dsg_pkg::GATE_RESET;
            auto_gate_q  <= 1'b0;
            irq_stat_q   <= 32'h0000_0000;
            irq_mask_q   <= 32'h0000_0000;
            fault_addr_q <= 32'h0000_0000;
            prdata_q     <= 32'h0000_0000;
            pslverr_q    <= 1'b0;
            fault_q      <= 1'b0;
            mode_q       <= dsg_pkg::DSG_MODE_RUN;
        end else begin
            run_gate_q   <= run_gate_d;
            sleep_gate_q <= sleep_gate_d;
            deep_gate_q  <= deep_gate_d;
            gate_q       <= gate_d;
            auto_gate_q  <= auto_gate_d;
            irq_stat_q   <= irq_stat_d;
            irq_mask_q   <= irq_mask_d;
            fault_addr_q <= fault_addr_d;
            prdata_q     <= prdata_d;
            pslverr_q    <= pslverr_d;
            fault_q      <= fault_d;
            mode_q       <= mode_d;
        end
    end

    // gated units get neither clock nor enable
    for (genvar g = 0; g < dsg_pkg::NUM_GATES; g++) begin : g_unit
        assign unit_clk_en[g] = gate_q[g];
        assign unit_enable[g] = gate_q[g];
    end

    assign prdata       = prdata_q;
    assign pslverr      = pslverr_q && psel && penable;
    assign pready       = psel && penable;
    assign periph_fault = fault_q;
    assign irq          = |(irq_stat_q & irq_mask_q);
endmodule : dsg_gate_bank

//--- tb/dsg_gate_bank_asserts.sv
`timescale 1ns/10ps
module dsg_gate_bank_asserts (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst,
    // bus and mode
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sleep_req,
    input wire logic        deep_sleep_req,
    // peripheral side
    input wire logic        periph_sel,
    input wire logic [4:0]  periph_page,
    input wire logic        periph_fault,
    input wire logic [31:0] unit_clk_en,
    input wire logic [31:0] unit_enable,
    input wire logic        irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    rdy_comb_a: assert property (pready == (psel && penable)) else $error("pready wrong");
    err_phase_a: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
    en_mask_a: assert property ((unit_clk_en & ~dsg_pkg::GATE_WR_MASK) == 32'h0) else $error("bad gate");
    en_pair_a: assert property (unit_enable == unit_clk_en) else $error("enable split");
    rst_clear_a: assert property ($fell(rst) |-> unit_clk_en == 32'h0 && !irq && !periph_fault)
        else $error("reset state");
    fault_off_a: assert property (periph_sel && !unit_clk_en[periph_page] |=> periph_fault)
        else $error("no fault");
    fault_on_a: assert property (periph_sel && unit_clk_en[periph_page] |=> !periph_fault)
        else $error("false fault");
    fault_idle_a: assert property (!periph_sel |=> !periph_fault) else $error("idle fault");
    en_hold_a: assert property ((!psel && $stable(sleep_req) && $stable(deep_sleep_req)) [*3] |=> $stable(unit_clk_en))
        else $error("gate drift");
endmodule : dsg_gate_bank_asserts

//--- tb/dsg_gate_bank_bench.sv
`timescale 1ns/10ps
module dsg_gate_bank_bench;
    logic        sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, er;
    logic        sleep_req = 0, deep_sleep_req = 0, periph_sel = 0, pready, pslverr, periph_fault, irq;
    logic [11:0] paddr = 12'h000, ra;
    logic [31:0] pwdata = 32'h0, prdata, unit_clk_en, unit_enable, rd, g[3];
    logic [4:0]  periph_page = 5'h0;
    int          failures = 0, compares = 0;
    dsg_gate_bank dut_u (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req), .periph_sel(periph_sel),
        .periph_page(periph_page), .periph_fault(periph_fault), .unit_clk_en(unit_clk_en),
        .unit_enable(unit_enable), .irq(irq));
    always #10 sys_clk = ~sys_clk;
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge sys_clk);
        penable <= 1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 0; penable <= 0;
    endtask : apb
    task chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            failures++;
            $display("Error t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task end_sim;
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim
    // model of the gate set in force
    function automatic logic [31:0] exp_en(logic a, logic s, logic d);
        return (a && d) ? g[2] : (a && s) ? g[1] : g[0];
    endfunction : exp_en
    initial begin
        #50000;
        failures++;
        end_sim;
    end
    initial begin
        void'($urandom(32'h6171));
        repeat (8) @(posedge sys_clk);
        rst <= 0;
        apb(0, dsg_pkg::DEEP_SLEEP_GATE_OFF, 32'h0); chk(rd, dsg_pkg::GATE_RESET);
        apb(1, dsg_pkg::DEEP_SLEEP_GATE_OFF, 32'hffff_ffff);
        apb(0, dsg_pkg::DEEP_SLEEP_GATE_OFF, 32'h0); chk(rd, 32'h030F_5033);
        for (int i = 0; i < 3; i++) begin
            // reserved ones written on purpose, must read back clear
            g[i] = $urandom & 32'h030F_5033;
            ra = i == 0 ? dsg_pkg::RUN_GATE_OFF : i == 1 ? dsg_pkg::SLEEP_GATE_OFF : dsg_pkg::DEEP_SLEEP_GATE_OFF;
            apb(1, ra, g[i] | 32'hfcf0_afcc);
            apb(0, ra, 32'h0); chk(rd, g[i]);
        end
        for (int m = 0; m < 9; m++) begin
            apb(1, dsg_pkg::RUN_CLOCK_CONFIG_OFF, 32'(m % 8 / 4) << dsg_pkg::AUTO_GATE_BIT);
            sleep_req <= m % 2 == 1;
            deep_sleep_req <= m % 4 / 2 == 1;
            repeat (3) @(posedge sys_clk);
            chk(unit_clk_en, exp_en(m % 8 / 4 == 1, m % 2 == 1, m % 4 / 2 == 1));
        end
        apb(1, dsg_pkg::IRQ_STATUS_OFF, 32'h0000_0003);
        apb(1, dsg_pkg::IRQ_MASK_OFF, 32'h0);
        for (int p = 0; p < 32; p++) begin
            @(posedge sys_clk) periph_sel <= 1; periph_page <= 5'(p);
            @(posedge sys_clk) periph_sel <= 0;
            #1 chk({31'h0, periph_fault}, {31'h0, !g[0][p]});
        end
        repeat (3) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h0);
        apb(1, dsg_pkg::IRQ_MASK_OFF, 32'h0000_0001);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h1);
        apb(0, dsg_pkg::FAULT_ADDR_OFF, 32'h0); chk(rd, 32'd31);
        apb(1, dsg_pkg::IRQ_STATUS_OFF, 32'h0000_0001);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h0);
        apb(1, 12'h300, 32'hffff_ffff); chk({31'h0, er}, 32'h1);
        apb(0, dsg_pkg::DEEP_SLEEP_GATE_OFF, 32'h0); chk(rd, g[2]);
        // read-modify-write keeps reserved bits as read
        apb(1, dsg_pkg::DEEP_SLEEP_GATE_OFF, rd ^ 32'h0000_0001);
        apb(0, dsg_pkg::DEEP_SLEEP_GATE_OFF, 32'h0); chk(rd, g[2] ^ 32'h0000_0001);
        end_sim;
    end
endmodule : dsg_gate_bank_bench
bind dsg_gate_bank dsg_gate_bank_asserts chk_u (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req),
    .periph_sel(periph_sel), .periph_page(periph_page), .periph_fault(periph_fault),
    .unit_clk_en(unit_clk_en), .unit_enable(unit_enable), .irq(irq));
